//--- verilog/mat_pkg.sv
// Constants, field layouts and types of the MAC address table block.
package mat_pkg;
	// Table sizes and widths.
	localparam int ST_ENTRIES = 8;
	localparam int ST_IDX_W = 3;
	localparam int ST_W = 58;
	localparam int DYN_ENTRIES = 1024;
	localparam int DYN_IDX_W = 10;
	localparam int DYN_RES_W = 72;
	localparam int MAC_W = 48;
	localparam int FILT_W = 4;
	localparam int WORD_W = 16;
	localparam int ADDR_W = 4;
	localparam int CNT_W = 11;

	// Static entry field positions.
	localparam int ST_FILT_HI = 57;
	localparam int ST_FILT_LO = 54;
	localparam int ST_USE_FILT = 53;
	localparam int ST_OVERRIDE = 52;
	localparam int ST_VALID = 51;
	localparam int ST_PORTS_HI = 50;
	localparam int ST_PORTS_LO = 48;
	localparam int MAC_HI = 47;

	// Dynamic read result field positions.
	localparam int DYN_NOT_READY = 71;
	localparam int DYN_EMPTY = 66;
	localparam int DYN_CNT_HI = 65;
	localparam int DYN_CNT_LO = 56;
	localparam int DYN_TS_HI = 55;
	localparam int DYN_TS_LO = 54;
	localparam int DYN_SRC_HI = 53;
	localparam int DYN_SRC_LO = 52;
	localparam int DYN_FILT_HI = 51;
	localparam int DYN_FILT_LO = 48;

	// Indirect control word layout and table codes.
	localparam int CTL_READ = 12;
	localparam int CTL_TBL_HI = 11;
	localparam int CTL_TBL_LO = 10;
	localparam int CTL_IDX_HI = 9;
	localparam logic [1:0] TBL_STATIC = 2'h0;
	localparam logic [1:0] TBL_DYNAMIC = 2'h2;

	// Register port addresses.
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_DW1 = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_DW2 = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_DW3 = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_DW4 = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_DW5 = 4'h5;

	// Reset values, aging and timing.
	localparam logic [ST_W-1:0] ST_RESET = 58'h00_0000_0000_0000;
	localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
	localparam logic [1:0] TS_FRESH = 2'h3;
	localparam logic [2:0] PORTS_BROADCAST = 3'h7;
	localparam logic [1:0] DYN_RD_WAIT = 2'h2;

	typedef enum logic [0:0] {
		MAT_IDLE = 1'b0,
		MAT_DYN_WAIT = 1'b1
	} mat_ind_t;
endpackage

//--- verilog/mat_lookup.sv
// Static and dynamic MAC address tables with look-up, learning, aging and indirect host access.
`timescale 1ns/1ns

// How it works
// - Destination look-up searches static and dynamic tables together every time.
// - Source look-up searches only the dynamic table for aging, migration, learning.
// - Static destination hit overrides any dynamic hit for the same frame.
// - Aging only removes dynamic entries; static entries never age out.
// - Static entry bits 57-54 hold filter identifier, reset zero.
// - Static bit 53 set compares filter identifier and MAC, else MAC only.
// - Static bit 52 set forwards despite disabled port transmit or receive.
// - Static bit 51 valid; invalid entries never produce a hit.
// - Static bits 50-48 port mask; 111 broadcasts excluding ingress port.
// - Eight static entries, 58 bits, MAC in 47-0, reset zero.
// - Static read: control word read code, then data words 3,2,5,4.
// - Static write: load data words, then control write commits entry.
// - Dynamic table holds 1024 entries and host writes never change it.
// - Dynamic read result bit 71 high until data is ready.
// - Dynamic bit 66 shows table empty, reset one.
// - Dynamic bits 65-56 show valid entry count minus one.
// - Dynamic entries carry 2-bit aging time stamp in bits 55-54.
// - Dynamic bits 53-52 record learning port, 00/01/10 for ports 1-3.
// - Dynamic bits 51-48 filter identifier, 47-0 learned MAC.
// - Dynamic read: control word, poll word one, then words 3,2,5,4.
module mat_lookup (
	input wire logic clk, // core clock
	input wire logic nrst, // asynchronous reset, active low
	input wire logic [mat_pkg::ADDR_W-1:0] regAddr, // register address
	input wire logic [mat_pkg::WORD_W-1:0] regWrData, // register write data
	input wire logic regWr, // register write strobe
	input wire logic regRd, // register read strobe
	output logic [mat_pkg::WORD_W-1:0] regRdData, // read data, cycle after strobe
	input wire logic dstLookup, // destination look-up request
	input wire logic [mat_pkg::MAC_W-1:0] dstMac, // destination address
	input wire logic [mat_pkg::FILT_W-1:0] dstFilt, // filter identifier of frame
	input wire logic [1:0] ingressPort, // ingress port code
	output logic fwdValid, // forwarding decision valid
	output logic [2:0] fwdPorts, // forwarding port mask
	output logic fwdOverride, // forward despite port enable settings
	output logic fwdStaticHit, // decision came from static table
	output logic fwdDynamicHit, // decision came from dynamic table
	input wire logic srcLookup, // source look-up request
	input wire logic [mat_pkg::MAC_W-1:0] srcMac, // source address
	input wire logic [mat_pkg::FILT_W-1:0] srcFilt, // filter identifier of frame
	input wire logic [1:0] srcPort, // port the frame arrived on
	input wire logic ageTick // starts one aging sweep
);
	import mat_pkg::*;

	// Direct-mapped placement keeps each look-up to one compare against a single hashed slot.
	function automatic logic [DYN_IDX_W-1:0] hashKey(input logic [MAC_W-1:0] mac,
			input logic [FILT_W-1:0] filt);
		hashKey = mac[9:0] ^ mac[19:10] ^ {filt, 6'h00};
	endfunction

	function automatic logic [2:0] portOneHot(input logic [1:0] p);
		portOneHot = 3'h1 << p;
	endfunction

	logic [ST_W-1:0] stEntry_r [ST_ENTRIES];
	logic [MAC_W-1:0] dynMac_r [DYN_ENTRIES];
	logic [FILT_W-1:0] dynFilt_r [DYN_ENTRIES];
	logic [1:0] dynSrc_r [DYN_ENTRIES];
	logic [1:0] dynTs_r [DYN_ENTRIES];
	logic [DYN_ENTRIES-1:0] dynValid_r;
	logic [CNT_W-1:0] validCnt_r;
	logic [WORD_W-1:0] ctrl_r;
	logic [WORD_W-1:0] dw1_r;
	logic [WORD_W-1:0] dw2_r;
	logic [WORD_W-1:0] dw3_r;
	logic [WORD_W-1:0] dw4_r;
	logic [WORD_W-1:0] dw5_r;
	logic [WORD_W-1:0] regRdData_r;
	mat_ind_t indState_r;
	logic [1:0] waitCnt_r;
	logic [DYN_IDX_W-1:0] rdIdx_r;
	logic ageRun_r;
	logic [DYN_IDX_W-1:0] agePtr_r;
	logic fwdValid_r;
	logic [2:0] fwdPorts_r;
	logic fwdOverride_r;
	logic fwdStaticHit_r;
	logic fwdDynamicHit_r;

	// Static destination match, one comparator per entry.
	logic [ST_ENTRIES-1:0] stHit;
	genvar g;
	for (g = 0; g < ST_ENTRIES; g++) begin : gStatic
		wire logic [ST_W-1:0] e = stEntry_r[g];
		wire logic macEq = e[MAC_HI:0] == dstMac;
		wire logic filtEq = e[ST_FILT_HI:ST_FILT_LO] == dstFilt;
		assign stHit[g] = e[ST_VALID] && macEq && (!e[ST_USE_FILT] || filtEq);
	end

	logic [ST_IDX_W-1:0] stSel;
	always_comb begin
		stSel = '0;
		for (int i = ST_ENTRIES - 1; i >= 0; i--) begin
			if (stHit[i]) begin
				stSel = ST_IDX_W'(i);
			end
		end
	end

	wire logic [ST_W-1:0] stWin = stEntry_r[stSel];
	wire logic stAny = |stHit;
	wire logic [2:0] stMask = stWin[ST_PORTS_HI:ST_PORTS_LO];
	wire logic [2:0] ingHot = portOneHot(ingressPort);
	wire logic [2:0] stPorts = (stMask == PORTS_BROADCAST) ? (stMask & ~ingHot) : stMask;

	// Dynamic destination match.
	wire logic [DYN_IDX_W-1:0] dstIdx = hashKey(dstMac, dstFilt);
	wire logic dynDstHit = dynValid_r[dstIdx] && dynMac_r[dstIdx] == dstMac
		&& dynFilt_r[dstIdx] == dstFilt;
	wire logic [2:0] dynPorts = portOneHot(dynSrc_r[dstIdx]);

	// Static result wins whenever both tables hit.
	wire logic [2:0] dstPorts = stAny ? stPorts : (dynDstHit ? dynPorts : 3'h0);
	wire logic dstOverride = stAny && stWin[ST_OVERRIDE];

	// Source look-up only touches the dynamic table; a hit or a miss both refresh the slot.
	wire logic [DYN_IDX_W-1:0] srcIdx = hashKey(srcMac, srcFilt);
	wire logic srcSlotUsed = dynValid_r[srcIdx];

	// Aging steps one slot per cycle and yields to learning on the same cycle.
	wire logic ageStep = ageRun_r && !srcLookup;
	wire logic ageKill = ageStep && dynValid_r[agePtr_r] && dynTs_r[agePtr_r] == 2'h0;
	wire logic learnNew = srcLookup && !srcSlotUsed;

	// Indirect control decoding.
	wire logic ctrlWr = regWr && regAddr == ADDR_CTRL;
	wire logic cmdRead = regWrData[CTL_READ];
	wire logic [1:0] cmdTbl = regWrData[CTL_TBL_HI:CTL_TBL_LO];
	wire logic [DYN_IDX_W-1:0] cmdIdx = regWrData[CTL_IDX_HI:0];
	wire logic stRdCmd = ctrlWr && cmdRead && cmdTbl == TBL_STATIC;
	wire logic stWrCmd = ctrlWr && !cmdRead && cmdTbl == TBL_STATIC;
	wire logic dynRdCmd = ctrlWr && cmdRead && cmdTbl == TBL_DYNAMIC;
	wire logic [ST_W-1:0] stRdEntry = stEntry_r[cmdIdx[ST_IDX_W-1:0]];
	wire logic [ST_W-1:0] stWrEntry = {dw3_r[9:0], dw2_r, dw5_r, dw4_r};
	wire logic dynDone = indState_r == MAT_DYN_WAIT && waitCnt_r == 2'h0;

	// Dynamic read result assembled from the selected slot and table state.
	wire logic tableEmpty = validCnt_r == '0;
	wire logic [CNT_W-1:0] cntLess = validCnt_r - CNT_W'(1);
	wire logic [9:0] cntField = tableEmpty ? 10'h000 : cntLess[9:0];
	wire logic [DYN_RES_W-1:0] dynResult = {1'b0, 4'h0, tableEmpty, cntField,
		dynTs_r[rdIdx_r], dynSrc_r[rdIdx_r], dynFilt_r[rdIdx_r], dynMac_r[rdIdx_r]};

	// Read-back selection; word one carries the live not-ready flag.
	wire logic busy = indState_r == MAT_DYN_WAIT;
	wire logic [WORD_W-1:0] dw1View = {8'h00, busy, dw1_r[6:0]};
	wire logic [WORD_W-1:0] rdMux =
		(regAddr == ADDR_CTRL) ? ctrl_r :
		(regAddr == ADDR_DW1) ? dw1View :
		(regAddr == ADDR_DW2) ? dw2_r :
		(regAddr == ADDR_DW3) ? dw3_r :
		(regAddr == ADDR_DW4) ? dw4_r :
		(regAddr == ADDR_DW5) ? dw5_r : WORD_RESET;

	// Static table storage.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < ST_ENTRIES; i++) begin
				stEntry_r[i] <= ST_RESET;
			end
		end else if (stWrCmd) begin
			stEntry_r[cmdIdx[ST_IDX_W-1:0]] <= stWrEntry;
		end
	end

	// Dynamic table storage: learning, migration and aging only, never the host.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dynValid_r <= '0;
			for (int i = 0; i < DYN_ENTRIES; i++) begin
				dynMac_r[i] <= '0;
				dynFilt_r[i] <= '0;
				dynSrc_r[i] <= '0;
				dynTs_r[i] <= '0;
			end
		end else if (srcLookup) begin
			dynValid_r[srcIdx] <= 1'b1;
			dynMac_r[srcIdx] <= srcMac;
			dynFilt_r[srcIdx] <= srcFilt;
			dynSrc_r[srcIdx] <= srcPort;
			dynTs_r[srcIdx] <= TS_FRESH;
		end else if (ageKill) begin
			dynValid_r[agePtr_r] <= 1'b0;
		end else if (ageStep && dynValid_r[agePtr_r]) begin
			dynTs_r[agePtr_r] <= dynTs_r[agePtr_r] - 2'h1;
		end
	end

	// A hit or a slot replacement leaves the count unchanged.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			validCnt_r <= '0;
		end else if (learnNew) begin
			validCnt_r <= validCnt_r + CNT_W'(1);
		end else if (ageKill) begin
			validCnt_r <= validCnt_r - CNT_W'(1);
		end
	end

	// Aging sweep over every dynamic slot.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ageRun_r <= 1'b0;
			agePtr_r <= '0;
		end else if (ageTick && !ageRun_r) begin
			ageRun_r <= 1'b1;
			agePtr_r <= '0;
		end else if (ageStep) begin
			agePtr_r <= agePtr_r + DYN_IDX_W'(1);
			if (agePtr_r == DYN_IDX_W'(DYN_ENTRIES - 1)) begin
				ageRun_r <= 1'b0;
			end
		end
	end

	// Indirect access sequencer; a new dynamic read command restarts any pending read, any other control write cancels it.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			indState_r <= MAT_IDLE;
			waitCnt_r <= '0;
			rdIdx_r <= '0;
			ctrl_r <= WORD_RESET;
		end else if (ctrlWr) begin
			ctrl_r <= regWrData;
			rdIdx_r <= cmdIdx;
			indState_r <= dynRdCmd ? MAT_DYN_WAIT : MAT_IDLE;
			waitCnt_r <= DYN_RD_WAIT - 2'h1;
		end else begin
			case (indState_r)
				MAT_IDLE: begin
					waitCnt_r <= '0;
				end
				MAT_DYN_WAIT: begin
					if (waitCnt_r == 2'h0) begin
						indState_r <= MAT_IDLE;
					end else begin
						waitCnt_r <= waitCnt_r - 2'h1;
					end
				end
				default: begin
					indState_r <= MAT_IDLE;
				end
			endcase
		end
	end

	// Data words: host loads words two to five, reads of either table refill them.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dw1_r <= WORD_RESET;
			dw2_r <= WORD_RESET;
			dw3_r <= WORD_RESET;
			dw4_r <= WORD_RESET;
			dw5_r <= WORD_RESET;
		end else if (stRdCmd) begin
			dw3_r <= {6'h00, stRdEntry[ST_FILT_HI:ST_PORTS_LO]};
			dw2_r <= stRdEntry[47:32];
			dw5_r <= stRdEntry[31:16];
			dw4_r <= stRdEntry[15:0];
		end else if (dynDone) begin
			dw1_r <= {8'h00, dynResult[71:64]};
			dw3_r <= dynResult[63:48];
			dw2_r <= dynResult[47:32];
			dw5_r <= dynResult[31:16];
			dw4_r <= dynResult[15:0];
		end else if (regWr) begin
			if (regAddr == ADDR_DW2) begin
				dw2_r <= regWrData;
			end
			if (regAddr == ADDR_DW3) begin
				dw3_r <= regWrData;
			end
			if (regAddr == ADDR_DW4) begin
				dw4_r <= regWrData;
			end
			if (regAddr == ADDR_DW5) begin
				dw5_r <= regWrData;
			end
		end
	end

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			regRdData_r <= WORD_RESET;
		end else begin
			regRdData_r <= regRd ? rdMux : WORD_RESET;
		end
	end

	// Forwarding decision, registered one cycle after the request.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fwdValid_r <= 1'b0;
			fwdPorts_r <= 3'h0;
			fwdOverride_r <= 1'b0;
			fwdStaticHit_r <= 1'b0;
			fwdDynamicHit_r <= 1'b0;
		end else begin
			fwdValid_r <= dstLookup;
			fwdPorts_r <= dstLookup ? dstPorts : 3'h0;
			fwdOverride_r <= dstLookup && dstOverride;
			fwdStaticHit_r <= dstLookup && stAny;
			fwdDynamicHit_r <= dstLookup && !stAny && dynDstHit;
		end
	end

	assign regRdData = regRdData_r;
	assign fwdValid = fwdValid_r;
	assign fwdPorts = fwdPorts_r;
	assign fwdOverride = fwdOverride_r;
	assign fwdStaticHit = fwdStaticHit_r;
	assign fwdDynamicHit = fwdDynamicHit_r;
endmodule

//--- verification/mat_lookup_sva.sv
// Concurrent checks on the look-up outputs and the indirect read port.
`timescale 1ns/1ns
module mat_lookup_sva (
	input wire logic clk, // core clock
	input wire logic nrst, // reset, active low
	input wire logic [mat_pkg::ADDR_W-1:0] regAddr, // register address
	input wire logic [mat_pkg::WORD_W-1:0] regWrData, // write data
	input wire logic regWr, // write strobe
	input wire logic regRd, // read strobe
	input wire logic [mat_pkg::WORD_W-1:0] regRdData, // read data
	input wire logic dstLookup, // look-up request
	input wire logic fwdValid, // decision valid
	input wire logic [2:0] fwdPorts, // port mask
	input wire logic fwdOverride, // override flag
	input wire logic fwdStaticHit, // static hit
	input wire logic fwdDynamicHit // dynamic hit
);
	import mat_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	sequence s_dynCmd;
		regWr && regAddr == ADDR_CTRL && regWrData[12:10] == 3'h6;
	endsequence
	sequence s_poll;
		regRd && regAddr == ADDR_DW1;
	endsequence
	property p_rdIdle;
		!$past(regRd) |-> regRdData == 16'h0000;
	endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("read data outside answer cycle");
	property p_fwdOne;
		dstLookup |=> fwdValid;
	endproperty
	a_fwdOne: assert property (p_fwdOne) else $error("look-up not answered");
	property p_fwdCause;
		fwdValid |-> $past(dstLookup);
	endproperty
	a_fwdCause: assert property (p_fwdCause) else $error("decision without request");
	property p_idle;
		!fwdValid |-> fwdPorts == 3'h0 && !fwdOverride && !fwdStaticHit && !fwdDynamicHit;
	endproperty
	a_idle: assert property (p_idle) else $error("decision outputs busy while idle");
	property p_staticWins;
		fwdStaticHit |-> !fwdDynamicHit;
	endproperty
	a_staticWins: assert property (p_staticWins) else $error("both hits reported");
	property p_ovr;
		fwdOverride |-> fwdStaticHit;
	endproperty
	a_ovr: assert property (p_ovr) else $error("override without static hit");
	property p_dynPort;
		fwdDynamicHit |-> $onehot(fwdPorts);
	endproperty
	a_dynPort: assert property (p_dynPort) else $error("dynamic hit mask not one port");
	property p_miss;
		fwdValid && !fwdStaticHit && !fwdDynamicHit |-> fwdPorts == 3'h0;
	endproperty
	a_miss: assert property (p_miss) else $error("miss with ports set");
	property p_notReady;
		s_dynCmd ##2 s_poll |=> regRdData[7];
	endproperty
	a_notReady: assert property (p_notReady) else $error("early poll shows ready");
	property p_ready;
		s_dynCmd ##1 (!regWr)[*3] ##1 s_poll |=> !regRdData[7];
	endproperty
	a_ready: assert property (p_ready) else $error("late poll still not ready");
endmodule
bind mat_lookup mat_lookup_sva i_sva (.clk(clk), .nrst(nrst), .regAddr(regAddr),
	.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
	.dstLookup(dstLookup), .fwdValid(fwdValid), .fwdPorts(fwdPorts),
	.fwdOverride(fwdOverride), .fwdStaticHit(fwdStaticHit), .fwdDynamicHit(fwdDynamicHit));

//--- verification/mat_host.sv
// Host processor model that reaches the tables through the indirect registers.
`timescale 1ns/1ns
module mat_host (
	input wire logic clk, // core clock
	output logic [mat_pkg::ADDR_W-1:0] regAddr, // register address
	output logic [mat_pkg::WORD_W-1:0] regWrData, // write data
	output logic regWr, // write strobe
	output logic regRd, // read strobe
	input wire logic [mat_pkg::WORD_W-1:0] regRdData // read data
);
	import mat_pkg::*;
	initial begin
		regAddr = 4'h0;
		regWrData = 16'h0000;
		regWr = 1'h0;
		regRd = 1'h0;
	end
	// A spare edge follows every strobe, so a strobe is never set twice in one step.
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'h1;
		@(posedge clk);
		regWr <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'h1;
		@(posedge clk);
		regRd <= 1'h0;
		@(negedge clk);
		d = regRdData;
	endtask
	task automatic stWr(input logic [2:0] i, input logic [57:0] e);
		wr(ADDR_DW3, {6'h00, e[57:48]});
		wr(ADDR_DW2, e[47:32]);
		wr(ADDR_DW5, e[31:16]);
		wr(ADDR_DW4, e[15:0]);
		wr(ADDR_CTRL, {13'h0000, i});
	endtask
	task automatic stRd(input logic [2:0] i, output logic [57:0] e);
		logic [15:0] w3, w2, w5, w4;
		wr(ADDR_CTRL, {13'h0200, i});
		rd(ADDR_DW3, w3);
		rd(ADDR_DW2, w2);
		rd(ADDR_DW5, w5);
		rd(ADDR_DW4, w4);
		e = {w3[9:0], w2, w5, w4};
	endtask
	task automatic dynRd(input logic [9:0] i, output logic [71:0] r, output int n);
		logic [15:0] w1, w3, w2, w5, w4;
		wr(ADDR_CTRL, {6'h06, i});
		n = 0;
		do begin
			rd(ADDR_DW1, w1);
			n++;
		end while (w1[7] && n < 8);
		rd(ADDR_DW3, w3);
		rd(ADDR_DW2, w2);
		rd(ADDR_DW5, w5);
		rd(ADDR_DW4, w4);
		r = {w1[7:0], w3, w2, w5, w4};
	endtask
endmodule

//--- verification/mat_lookup_tb.sv
// Self-checking bench for the MAC address table block.
`timescale 1ns/1ns
module mat_lookup_tb;
	import mat_pkg::*;
	localparam logic [47:0] MAC_A = 48'h0a0b_0c0d_0e0f;
	localparam logic [47:0] MAC_B = 48'h0000_0000_0005;
	localparam logic [47:0] MAC_C = 48'h0000_1234_5678;
	logic clk, nrst, dstLookup, srcLookup, ageTick;
	logic [MAC_W-1:0] dstMac, srcMac;
	logic [FILT_W-1:0] dstFilt, srcFilt;
	logic [1:0] ingressPort, srcPort;
	wire logic [ADDR_W-1:0] regAddr;
	wire logic [WORD_W-1:0] regWrData, regRdData;
	wire logic regWr, regRd, fwdValid, fwdOverride, fwdStaticHit, fwdDynamicHit;
	wire logic [2:0] fwdPorts;
	int miscompares = 0;
	int num_checks = 0;
	logic [57:0] st;
	logic [71:0] dy;
	logic [15:0] w;
	int n;
	mat_lookup i_dut (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .dstLookup(dstLookup),
		.dstMac(dstMac), .dstFilt(dstFilt), .ingressPort(ingressPort), .fwdValid(fwdValid),
		.fwdPorts(fwdPorts), .fwdOverride(fwdOverride), .fwdStaticHit(fwdStaticHit),
		.fwdDynamicHit(fwdDynamicHit), .srcLookup(srcLookup), .srcMac(srcMac),
		.srcFilt(srcFilt), .srcPort(srcPort), .ageTick(ageTick));
	mat_host i_host (.clk(clk), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData));
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [71:0] got, input logic [71:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	// Expected code is {valid, static, dynamic, override, ports}.
	task automatic look(input logic [47:0] m, input logic [3:0] f, input logic [1:0] p,
		input logic [6:0] exp, input string nm);
		@(posedge clk);
		dstMac <= m;
		dstFilt <= f;
		ingressPort <= p;
		dstLookup <= 1'h1;
		@(posedge clk);
		dstLookup <= 1'h0;
		@(negedge clk);
		chk(nm, 72'({fwdValid, fwdStaticHit, fwdDynamicHit, fwdOverride, fwdPorts}), 72'(exp));
	endtask
	task automatic dynChk(input logic [9:0] i, input logic [71:0] exp, input string nm);
		i_host.dynRd(i, dy, n);
		if (n >= 8) begin
			miscompares++;
			wrap_up();
		end
		chk("polls", 72'(n), 72'h2);
		chk(nm, dy, exp);
	endtask
	task automatic tReset();
		i_host.stRd(3'h3, st);
		chk("stReset", 72'(st), 72'h0);
		dynChk(10'h000, 72'h04_0000_0000_0000_0000, "dynReset");
		i_host.rd(4'h6, w);
		chk("unmapped", 72'(w), 72'h0);
	endtask
	task automatic tStatic();
		i_host.stWr(3'h7, {10'h17f, MAC_A});
		i_host.stRd(3'h7, st);
		chk("stRead", 72'(st), 72'({10'h17f, MAC_A}));
		look(MAC_A, 4'h5, 2'h1, 7'h6d, "bcast");
		look(MAC_A, 4'h4, 2'h1, 7'h40, "fidKey");
		i_host.stWr(3'h6, {10'h24a, MAC_C});
		look(MAC_C, 4'h3, 2'h0, 7'h62, "macOnly");
		i_host.stWr(3'h6, {10'h002, MAC_C});
		look(MAC_C, 4'h3, 2'h0, 7'h40, "invalid");
	endtask
	task automatic tLearn();
		@(posedge clk);
		srcMac <= MAC_B;
		srcFilt <= 4'h0;
		srcPort <= 2'h2;
		srcLookup <= 1'h1;
		@(posedge clk);
		srcLookup <= 1'h0;
		look(MAC_B, 4'h0, 2'h0, 7'h54, "dynHit");
		look(MAC_B, 4'h1, 2'h0, 7'h40, "dynFilt");
		dynChk(10'h005, {16'h0000, 2'h3, 2'h2, 4'h0, MAC_B}, "dynEntry");
		i_host.wr(ADDR_DW4, 16'hffff);
		i_host.wr(ADDR_CTRL, 16'h0805);
		dynChk(10'h005, {16'h0000, 2'h3, 2'h2, 4'h0, MAC_B}, "dynRO");
		i_host.stWr(3'h0, {10'h009, MAC_B});
		look(MAC_B, 4'h0, 2'h2, 7'h61, "staticWins");
	endtask
	task automatic tAging();
		for (int k = 1; k <= 4; k++) begin
			@(posedge clk);
			ageTick <= 1'h1;
			@(posedge clk);
			ageTick <= 1'h0;
			repeat (1100) @(posedge clk);
			if (k < 4) begin
				dynChk(10'h005, {16'h0000, 2'(3 - k), 2'h2, 4'h0, MAC_B}, "ts");
			end
		end
		dynChk(10'h005, {8'h04, 8'h00, 2'h0, 2'h2, 4'h0, MAC_B}, "agedOut");
		look(MAC_A, 4'h5, 2'h1, 7'h6d, "stKept");
	endtask
	initial begin
		nrst = 1'h0;
		dstLookup = 1'h0;
		srcLookup = 1'h0;
		ageTick = 1'h0;
		dstMac = 48'h0;
		srcMac = 48'h0;
		dstFilt = 4'h0;
		srcFilt = 4'h0;
		ingressPort = 2'h0;
		srcPort = 2'h0;
		repeat (12) @(posedge clk);
		nrst <= 1'h1;
		tReset();
		tStatic();
		tLearn();
		tAging();
		wrap_up();
	end
endmodule
